// File: common/lam_pkg.sv
package lam_pkg;
   localparam int NCH = 4;
   localparam int AW  = 8;
   // Register byte offsets.
   localparam logic [7:0] A_MCTRL   = 8'h00;
   localparam logic [7:0] A_MSTAT   = 8'h04;
   localparam logic [7:0] A_COMM    = 8'h08;
   localparam logic [7:0] A_OUT     = 8'h0C;
   localparam logic [3:0] A_CH_FIRST = 4'h1;
   localparam logic [3:0] A_CH_LAST  = 4'h4;
   localparam logic [3:0] A_CH_STAT  = 4'h5;
   localparam logic [1:0] F_CFG = 2'h0;
   localparam logic [1:0] F_HI  = 2'h1;
   localparam logic [1:0] F_LO  = 2'h2;
   localparam logic [1:0] F_DB  = 2'h3;
   // Field positions.
   localparam int MCTRL_SRST_B  = 0;
   localparam int MCTRL_WDEN_B  = 1;
   localparam int MCTRL_WDT_LSB = 16;
   localparam int MSTAT_LIM_B   = 0;
   localparam int MSTAT_WDTO_B  = 1;
   localparam int MSTAT_DEF_B   = 2;
   localparam int COMM_PAR_LSB  = 8;
   localparam int COMM_BAUD_LSB = 12;
   localparam int OUT_CLR_LSB   = 4;
   localparam int CST_LO_B      = 1;
   localparam int CST_ALM_B     = 2;
   localparam int CST_VAL_LSB   = 16;
   // Reset values; the input span is +/-20000 counts for +/-100 percent.
   localparam logic signed [15:0] SPAN_MAX = 16'sh4E20;
   localparam logic signed [15:0] SPAN_MIN = -16'sh4E20;
   localparam logic signed [15:0] DB_RST   = 16'sh0000;
   localparam logic [7:0]  DEF_ADDR     = 8'hF7;
   localparam logic [16:0] DEF_BAUD     = 17'h02580;
   localparam logic [1:0]  DEF_PARITY   = 2'h0;
   localparam logic [7:0]  NV_ADDR_RST  = 8'h01;
   localparam logic [16:0] NV_BAUD_RST  = 17'h02580;
   localparam logic [1:0]  NV_PAR_RST   = 2'h0;
   localparam logic [15:0] WDT_RST      = 16'h0000;
   localparam logic [1:0]  RESP_OK      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;
   // Timing.
   localparam int CLK_PERIOD_NS = 10;
   localparam int SEC_NS        = 1_000_000_000;
   localparam int SEC_CYC       = SEC_NS / CLK_PERIOD_NS;

   typedef struct packed {
      logic               hi_en;
      logic               lo_en;
      logic               failsafe;
      logic               wd_val;
      logic signed [15:0] hi;
      logic signed [15:0] lo;
      logic signed [15:0] db;
   } lam_ch_cfg_s;

   typedef struct packed {
      logic hi_flag;
      logic lo_flag;
      logic alarm;
      logic enter;
   } lam_ch_st_s;
endpackage

// File: core/lam_wdog.sv
`timescale 1ns/1ps
module lam_wdog #(
   parameter int SEC_CYC = lam_pkg::SEC_CYC
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        srst,
   input  wire logic [15:0] timeout_s,
   input  wire logic        io_access,
   output logic             timed_out
);
   import lam_pkg::*;
   logic [31:0] pre_r;
   logic [15:0] sec_r;
   logic        sec_tick;
   logic        timed_out_r;

   assign sec_tick  = (pre_r == 32'(SEC_CYC - 1));
   assign timed_out = timed_out_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_r <= '0;
      end else if (srst || io_access || sec_tick) begin
         pre_r <= '0;
      end else begin
         pre_r <= pre_r + 32'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sec_r <= '0;
      end else if (srst || io_access) begin
         sec_r <= '0;
      end else if (sec_tick && sec_r != 16'hFFFF) begin
         sec_r <= sec_r + 16'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         timed_out_r <= 1'b0;
      end else if (srst || io_access || timeout_s == 16'h0) begin
         timed_out_r <= 1'b0;
      end else if (sec_tick && sec_r + 16'h1 >= timeout_s) begin
         timed_out_r <= 1'b1;
      end
   end

   a_wd_fires: assert property (@(posedge clk) disable iff (!rst_n)
      !srst && !io_access && timeout_s != 16'h0 && sec_tick && sec_r + 16'h1 == timeout_s |=> timed_out)
      else $error("watchdog did not fire at its timeout");
   a_wd_restart: assert property (@(posedge clk) disable iff (!rst_n)
      io_access |=> !timed_out && sec_r == 16'h0)
      else $error("host access did not restart the watchdog");
endmodule

// File: core/lam_chan.sv
`timescale 1ns/1ps
module lam_chan (
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic                srst,
   input  wire lam_pkg::lam_ch_cfg_s cfg,
   input  wire logic signed [15:0]  in_value,
   input  wire logic                scan,
   input  wire logic                wd_to,
   input  wire logic                cmd_set,
   input  wire logic                cmd_clr,
   output logic                     out_on,
   output logic                     led,
   output lam_pkg::lam_ch_st_s      st
);
   import lam_pkg::*;
   logic signed [17:0] v, hi, lo, hi_rel, lo_rel;
   logic hi_alm_r, lo_alm_r, hi_nxt, lo_nxt, in_db, in_db_r, alm_en, alarm_nxt, alarm_r, out_r;

   // Wide arithmetic keeps limit minus deadband from wrapping at the span ends.
   assign v      = 18'(in_value);
   assign hi     = 18'(cfg.hi);
   assign lo     = 18'(cfg.lo);
   assign hi_rel = hi - 18'(cfg.db);
   assign lo_rel = lo + 18'(cfg.db);
   assign alm_en = cfg.hi_en | cfg.lo_en;

   // Limit comparison runs whether or not the output is alarm enabled.
   always_comb begin
      hi_nxt = hi_alm_r;
      lo_nxt = lo_alm_r;
      if (v >= hi) begin
         hi_nxt = 1'b1;
      end else if (v <= hi_rel) begin
         hi_nxt = 1'b0;
      end
      if (v <= lo) begin
         lo_nxt = 1'b1;
      end else if (v >= lo_rel) begin
         lo_nxt = 1'b0;
      end
      in_db = (cfg.hi_en && v < hi && v > hi_rel) || (cfg.lo_en && v > lo && v < lo_rel);
      alarm_nxt = (cfg.hi_en & hi_nxt) | (cfg.lo_en & lo_nxt);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hi_alm_r <= 1'b0;
         lo_alm_r <= 1'b0;
         alarm_r  <= 1'b0;
         in_db_r  <= 1'b0;
      end else if (srst) begin
         hi_alm_r <= 1'b0;
         lo_alm_r <= 1'b0;
         alarm_r  <= 1'b0;
         in_db_r  <= 1'b0;
      end else if (scan) begin
         hi_alm_r <= hi_nxt;
         lo_alm_r <= lo_nxt;
         alarm_r  <= alarm_nxt;
         in_db_r  <= in_db;
      end
   end

   // Watchdog forcing, then alarm re-drive on each scan outside the deadband, then direct commands.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_r <= 1'b0;
      end else if (srst) begin
         out_r <= 1'b0;
      end else if (wd_to) begin
         out_r <= cfg.wd_val;
      end else if (alm_en && scan && !in_db) begin
         out_r <= alarm_nxt ^ cfg.failsafe;
      end else if (!alm_en || in_db_r) begin
         if (cmd_set) begin
            out_r <= 1'b1;
         end else if (cmd_clr) begin
            out_r <= 1'b0;
         end
      end
   end

   assign out_on     = out_r;
   assign led        = alarm_r & alm_en;
   assign st.hi_flag = hi_alm_r;
   assign st.lo_flag = lo_alm_r;
   assign st.alarm   = alarm_r;
   assign st.enter   = scan && !srst && alarm_nxt && !alarm_r;

   a_wd_force: assert property (@(posedge clk) disable iff (!rst_n)
      wd_to && !srst |=> out_on == $past(cfg.wd_val))
      else $error("watchdog did not force the output");
   a_alarm_drive: assert property (@(posedge clk) disable iff (!rst_n)
      !srst && !wd_to && alm_en && scan && !in_db |=> out_on == ($past(alarm_nxt) ^ $past(cfg.failsafe)))
      else $error("alarm scan did not re-drive the output");
   a_hi_trip: assert property (@(posedge clk) disable iff (!rst_n)
      !srst && scan && v >= hi |=> st.hi_flag)
      else $error("high limit not flagged");
   a_lo_trip: assert property (@(posedge clk) disable iff (!rst_n)
      !srst && scan && v <= lo |=> st.lo_flag)
      else $error("low limit not flagged");
   a_direct_block: assert property (@(posedge clk) disable iff (!rst_n)
      !srst && !wd_to && alm_en && !scan && !in_db_r |=> out_on == $past(out_on))
      else $error("direct command moved an alarm controlled output");
endmodule

// File: core/lam_top.sv
// Local design decisions: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
// Function
// - Hi/lo alarm enables hand output to alarms.
// - Rising input at or above high trips.
// - Falling input at or below low trips.
// - Alarm clears only past limit by deadband.
// - Limits and deadband span full input range.
// - Failsafe mode turns output off in alarm.
// - Non-failsafe turns output on in alarm.
// - Every scan re-drives alarm enabled outputs; here scans inside deadband do not.
// - Inside deadband, direct commands take effect.
// - Any alarm entry sets global flag.
// - Per-channel high and low limit flags.
// - Status indicator shows output in alarm.
// - Watchdog timeout forces configured output value.
// - Priority: watchdog, then alarm, then direct.
// - Clearing timeout keeps forced value, returns control.
// - Any host access restarts the watchdog.
// - Direct set/clear only when not overridden.
// - Values are signed, +/-20000 full span.
// - Commanded reset equals power-on reset.
// - After reset leave default comm mode.
// - Configuration retained and readable back.
// - Watchdog in seconds, zero disables it.
// - Limits always compared, default range endpoints.
// - Default mode uses 9600, 247, no parity.
module lam_top #(
   parameter int NCH     = lam_pkg::NCH,
   parameter int SEC_CYC = lam_pkg::SEC_CYC
) (
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   input  wire logic [lam_pkg::AW-1:0]     s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   input  wire logic [lam_pkg::AW-1:0]     s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   output logic [31:0]                     s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   input  wire logic [NCH-1:0][15:0]       in_value,
   input  wire logic                       in_scan,
   input  wire logic                       default_sw,
   output logic [NCH-1:0]                  out_on,
   output logic [NCH-1:0]                  out_led,
   output logic [7:0]                      comm_addr,
   output logic [16:0]                     comm_baud,
   output logic [1:0]                      comm_parity,
   output logic                            default_mode
);
   import lam_pkg::*;
   lam_ch_cfg_s        cfg_r [NCH];
   lam_ch_st_s         st [NCH];
   logic [15:0]        wdt_r;
   logic               wden_r, soft_rst_r, gflag_r, boot_r, def_r, wd_to;
   logic [7:0]         addr_r;
   logic [16:0]        baud_r;
   logic [1:0]         par_r;
   logic [NCH-1:0]     set_r, clr_r, wd_out, enter;
   logic [AW-1:0]      awaddr_r;
   logic [31:0]        wdata_r, rdata_r;
   logic [3:0]         wstrb_r;
   logic               aw_ok_r, w_ok_r, bvalid_r, rvalid_r, do_wr, io_access;
   logic [1:0]         bresp_r, rresp_r;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[b*8 +: 8] = d[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic mapped(input logic [AW-1:0] a, input logic rd);
      logic ok;
      ok = (a[1:0] == 2'h0) &&
           (a == A_MCTRL || a == A_MSTAT || a == A_COMM || a == A_OUT ||
            (a[7:4] >= A_CH_FIRST && a[7:4] <= A_CH_LAST) ||
            (rd && a[7:4] == A_CH_STAT && int'(a[3:2]) < NCH));
      return ok;
   endfunction

   // AXI4-Lite write: address and data are taken independently, answered together.
   assign s_axi_awready = !aw_ok_r && !bvalid_r;
   assign s_axi_wready  = !w_ok_r && !bvalid_r;
   assign do_wr         = aw_ok_r && w_ok_r && !bvalid_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
   assign io_access     = (s_axi_awvalid && s_axi_awready) || (s_axi_arvalid && s_axi_arready);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_ok_r  <= 1'b0;
         w_ok_r   <= 1'b0;
         awaddr_r <= '0;
         wdata_r  <= '0;
         wstrb_r  <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_ok_r  <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end else if (do_wr) begin
            aw_ok_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_ok_r  <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end else if (do_wr) begin
            w_ok_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bvalid_r <= 1'b0;
         bresp_r  <= RESP_OK;
      end else if (do_wr) begin
         bvalid_r <= 1'b1;
         bresp_r  <= mapped(awaddr_r, 1'b0) ? RESP_OK : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // Configuration survives a commanded reset, as nonvolatile storage would.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wdt_r  <= WDT_RST;
         wden_r <= 1'b0;
         addr_r <= NV_ADDR_RST;
         baud_r <= NV_BAUD_RST;
         par_r  <= NV_PAR_RST;
         for (int c = 0; c < NCH; c++) begin
            cfg_r[c] <= '{hi_en: 1'b0, lo_en: 1'b0, failsafe: 1'b0, wd_val: 1'b0,
                          hi: SPAN_MAX, lo: SPAN_MIN, db: DB_RST};
         end
      end else if (do_wr) begin
         if (awaddr_r == A_MCTRL) begin
            wdt_r  <= 16'(merge({wdt_r, 14'h0, wden_r, 1'b0}, wdata_r, wstrb_r) >> MCTRL_WDT_LSB);
            wden_r <= 1'(merge({wdt_r, 14'h0, wden_r, 1'b0}, wdata_r, wstrb_r) >> MCTRL_WDEN_B);
         end
         if (awaddr_r == A_COMM) begin
            addr_r <= 8'(merge({3'h0, baud_r, 2'h0, par_r, addr_r}, wdata_r, wstrb_r));
            par_r  <= 2'(merge({3'h0, baud_r, 2'h0, par_r, addr_r}, wdata_r, wstrb_r) >> COMM_PAR_LSB);
            baud_r <= 17'(merge({3'h0, baud_r, 2'h0, par_r, addr_r}, wdata_r, wstrb_r) >> COMM_BAUD_LSB);
         end
         for (int c = 0; c < NCH; c++) begin
            if (awaddr_r[7:4] == 4'(c + 1) && awaddr_r[1:0] == 2'h0) begin
               case (awaddr_r[3:2])
                  F_CFG: {cfg_r[c].wd_val, cfg_r[c].failsafe, cfg_r[c].lo_en, cfg_r[c].hi_en} <=
                            4'(merge({28'h0, cfg_r[c].wd_val, cfg_r[c].failsafe, cfg_r[c].lo_en, cfg_r[c].hi_en},
                                  wdata_r, wstrb_r));
                  F_HI:  cfg_r[c].hi <= 16'(merge({16'h0, cfg_r[c].hi}, wdata_r, wstrb_r));
                  F_LO:  cfg_r[c].lo <= 16'(merge({16'h0, cfg_r[c].lo}, wdata_r, wstrb_r));
                  F_DB:  cfg_r[c].db <= 16'(merge({16'h0, cfg_r[c].db}, wdata_r, wstrb_r));
                  default: cfg_r[c].db <= cfg_r[c].db;
               endcase
            end
         end
      end
   end

   // Commands that act for one cycle: module reset and direct output set/clear.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         soft_rst_r <= 1'b0;
         set_r      <= '0;
         clr_r      <= '0;
      end else begin
         soft_rst_r <= do_wr && awaddr_r == A_MCTRL && wstrb_r[0] && wdata_r[MCTRL_SRST_B];
         set_r      <= (do_wr && awaddr_r == A_OUT && wstrb_r[0]) ? wdata_r[NCH-1:0] : '0;
         clr_r      <= (do_wr && awaddr_r == A_OUT && wstrb_r[0]) ? wdata_r[OUT_CLR_LSB +: NCH] : '0;
      end
   end

   // The default mode strap is caught on the first cycle after each rst_n release; a commanded reset leaves default mode.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         boot_r <= 1'b1;
         def_r  <= 1'b0;
      end else begin
         boot_r <= 1'b0;
         if (soft_rst_r) begin
            def_r <= 1'b0;
         end else if (boot_r) begin
            def_r <= default_sw;
         end
      end
   end

   assign default_mode = def_r;
   assign comm_addr    = def_r ? DEF_ADDR : addr_r;
   assign comm_baud    = def_r ? DEF_BAUD : baud_r;
   assign comm_parity  = def_r ? DEF_PARITY : par_r;

   // Global limit flag: write one to clear, a new alarm entry wins over the clear.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gflag_r <= 1'b0;
      end else if (soft_rst_r) begin
         gflag_r <= 1'b0;
      end else if (|enter) begin
         gflag_r <= 1'b1;
      end else if (do_wr && awaddr_r == A_MSTAT && wstrb_r[0] && wdata_r[MSTAT_LIM_B]) begin
         gflag_r <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rvalid_r <= 1'b0;
         rdata_r  <= '0;
         rresp_r  <= RESP_OK;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_r <= 1'b1;
         rresp_r  <= mapped(s_axi_araddr, 1'b1) ? RESP_OK : RESP_SLVERR;
         rdata_r  <= '0;
         case (s_axi_araddr)
            A_MCTRL: rdata_r <= {wdt_r, 14'h0, wden_r, 1'b0};
            A_MSTAT: rdata_r <= {29'h0, def_r, wd_to, gflag_r};
            A_COMM:  rdata_r <= {3'h0, baud_r, 2'h0, par_r, addr_r};
            A_OUT:   rdata_r <= 32'(out_on);
            default: begin
               for (int c = 0; c < NCH; c++) begin
                  if (s_axi_araddr[7:4] == 4'(c + 1) && s_axi_araddr[1:0] == 2'h0) begin
                     case (s_axi_araddr[3:2])
                        F_CFG:   rdata_r <= {28'h0, cfg_r[c].wd_val, cfg_r[c].failsafe, cfg_r[c].lo_en,
                                             cfg_r[c].hi_en};
                        F_HI:    rdata_r <= 32'(cfg_r[c].hi);
                        F_LO:    rdata_r <= 32'(cfg_r[c].lo);
                        default: rdata_r <= 32'(cfg_r[c].db);
                     endcase
                  end
                  if (s_axi_araddr == {A_CH_STAT, 2'(c), 2'h0}) begin
                     rdata_r <= {in_value[c], 13'h0, st[c].alarm, st[c].lo_flag, st[c].hi_flag};
                  end
               end
            end
         endcase
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   lam_wdog #(.SEC_CYC(SEC_CYC)) u_wdog (
      .clk       (clk),
      .rst_n     (rst_n),
      .srst      (soft_rst_r),
      .timeout_s (wdt_r),
      .io_access (io_access),
      .timed_out (wd_to)
   );

   // Each channel is its own alarm and arbitration copy; forcing ends without restoring outputs.
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         assign wd_out[g] = wd_to && wden_r;
         assign enter[g]  = st[g].enter;
         lam_chan u_chan (
            .clk      (clk),
            .rst_n    (rst_n),
            .srst     (soft_rst_r),
            .cfg      (cfg_r[g]),
            .in_value (in_value[g]),
            .scan     (in_scan),
            .wd_to    (wd_out[g]),
            .cmd_set  (set_r[g]),
            .cmd_clr  (clr_r[g]),
            .out_on   (out_on[g]),
            .led      (out_led[g]),
            .st       (st[g])
         );
      end
   endgenerate

   a_gflag_set: assert property (@(posedge clk) disable iff (!rst_n)
      !soft_rst_r && (|enter) |=> gflag_r)
      else $error("alarm entry did not set the global flag");
   a_soft_reset: assert property (@(posedge clk) disable iff (!rst_n)
      soft_rst_r |=> !def_r && !gflag_r && out_on == '0)
      else $error("commanded reset did not act as power-on reset");
   a_default_comm: assert property (@(posedge clk) disable iff (!rst_n)
      def_r |-> comm_addr == DEF_ADDR && comm_baud == DEF_BAUD && comm_parity == DEF_PARITY)
      else $error("default mode settings wrong");
   a_bresp_follow: assert property (@(posedge clk) disable iff (!rst_n)
      do_wr |=> s_axi_bvalid)
      else $error("write answered late");
endmodule

// File: bench/lam_host.sv
`timescale 1ns/1ps
module lam_host (
   input  wire logic        clk,
   output logic [7:0]       s_axi_awaddr,
   output logic             s_axi_awvalid,
   input  wire logic        s_axi_awready,
   output logic [31:0]      s_axi_wdata,
   output logic [3:0]       s_axi_wstrb,
   output logic             s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   output logic             s_axi_bready,
   output logic [7:0]       s_axi_araddr,
   output logic             s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   output logic             s_axi_rready
);
   logic [1:0] bresp_seen = 2'h0;
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
   end
   // Released payloads are inverted so a stale value is never mistaken for data.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a;
         end
         if (s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~d;
         end
      end while (!s_axi_bvalid);
      bresp_seen = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      s_axi_araddr <= ~a;
   endtask
endmodule

// File: bench/lam_top_tb.sv
`timescale 1ns/1ps
module lam_top_tb;
   import lam_pkg::*;
   logic clk = 0, rst_n = 0, in_scan = 0, default_sw = 0;
   logic [3:0][15:0] in_value = '0;
   logic [7:0] s_axi_awaddr, s_axi_araddr, comm_addr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb, out_on, out_led;
   logic [1:0] s_axi_bresp, s_axi_rresp, comm_parity, r;
   logic [16:0] comm_baud;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, default_mode;
   int fail_count = 0, n_compared = 0, cyc = 0;
   always #5 clk = ~clk;
   lam_top #(.SEC_CYC(20)) i_dut (.*);
   lam_host i_host (.*);
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic scan(input int c, input logic [15:0] v);
      @(posedge clk);
      in_value[c] <= v;
      @(posedge clk);
      in_scan <= 1'b1;
      @(posedge clk);
      in_scan <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic t_reset();
      chk(32'(comm_addr), 32'(NV_ADDR_RST));
      chk(32'({comm_parity, comm_baud}), 32'({NV_PAR_RST, NV_BAUD_RST}));
      chk(32'(default_mode), 32'h0);
      i_host.rd(8'hFC, d, r);
      chk(32'(r), 32'(RESP_SLVERR));
      chk(d, 32'h0);
   endtask
   task automatic t_default();
      @(posedge clk);
      default_sw <= 1'b1;
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      chk(32'(default_mode), 32'h1);
      chk(32'({comm_parity, comm_baud, comm_addr}), 32'({DEF_PARITY, DEF_BAUD, DEF_ADDR}));
      i_host.wr(A_COMM, 32'h04B00105);
      i_host.rd(A_COMM, d, r);
      chk(d, 32'h04B00105);
      chk(32'(comm_addr), 32'(DEF_ADDR));
      i_host.wr(A_MCTRL, 32'h00000001);
      repeat (2) @(posedge clk);
      chk(32'(default_mode), 32'h0);
      chk(32'({comm_parity, comm_baud, comm_addr}), 32'h024B0005);
   endtask
   task automatic t_high();
      i_host.wr(8'h14, 32'h000003E8);
      chk(32'(i_host.bresp_seen), 32'(RESP_OK));
      i_host.wr(8'h1C, 32'h00000064);
      i_host.wr(8'h10, 32'h00000001);
      i_host.rd(8'h14, d, r);
      chk(32'(d[15:0]), 32'h3E8);
      scan(0, 16'h03E7);
      chk(32'(out_on[0]), 32'h0);
      scan(0, 16'h03E8);
      chk(32'(out_on[0]), 32'h1);
      chk(32'(out_led[0]), 32'h1);
      i_host.rd(A_MSTAT, d, r);
      chk(32'(d[0]), 32'h1);
      i_host.rd(8'h50, d, r);
      chk(32'(d[2:0]), 32'h5);
      chk(32'(r), 32'(RESP_OK));
      chk(32'(d[31:16]), 32'h3E8);
      i_host.wr(A_OUT, 32'h00000010);
      repeat (4) @(posedge clk);
      chk(32'(out_on[0]), 32'h1);
      scan(0, 16'h03B6);
      i_host.wr(A_OUT, 32'h00000010);
      repeat (4) @(posedge clk);
      chk(32'(out_on[0]), 32'h0);
      scan(0, 16'h0384);
      i_host.rd(8'h50, d, r);
      chk(32'(d[2]), 32'h0);
   endtask
   task automatic t_low();
      i_host.wr(8'h28, 32'hFFFFFC18);
      i_host.wr(8'h20, 32'h00000006);
      scan(1, 16'h0000);
      chk(32'(out_on[1]), 32'h1);
      scan(1, 16'hFC18);
      chk(32'(out_on[1]), 32'h0);
      i_host.rd(8'h60, d, r);
      chk(32'(r), 32'(RESP_SLVERR));
      chk(d, 32'h0);
      i_host.wr(8'h60, 32'h00000000);
      chk(32'(i_host.bresp_seen), 32'(RESP_SLVERR));
      i_host.rd(8'h54, d, r);
      chk(32'(d[1]), 32'h1);
   endtask
   task automatic t_direct_wdog();
      i_host.wr(A_OUT, 32'h00000004);
      repeat (4) @(posedge clk);
      chk(32'(out_on[2]), 32'h1);
      i_host.wr(8'h40, 32'h00000008);
      i_host.wr(A_MCTRL, 32'h00010002);
      repeat (8) @(posedge clk);
      chk(32'(out_on[3]), 32'h0);
      repeat (80) @(posedge clk);
      chk(32'(out_on[3:2]), 32'h2);
      i_host.rd(A_MSTAT, d, r);
      chk(32'(d[1]), 32'h1);
      repeat (4) @(posedge clk);
      chk(32'(out_on[3]), 32'h1);
      i_host.wr(A_MCTRL, 32'h00000001);
      repeat (4) @(posedge clk);
      chk(32'(out_on), 32'h0);
      i_host.rd(8'h14, d, r);
      chk(32'(d[15:0]), 32'h3E8);
   endtask
   task automatic summarize();
      if (fail_count == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         fail_count++;
         summarize();
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_high();
      t_low();
      t_direct_wdog();
      t_default();
      summarize();
   end
endmodule
